/* verilog/pet_regs.svh */
/*
 * register offsets, field positions, reset values and timing counts
 * of the two-output pwm edge timing block.
 * assumes: included by bare name; holds definitions only.
 */
`ifndef PET_REGS_SVH
`define PET_REGS_SVH

// ==========================================================
// register offsets
`define PET_ADDR_FIRST_RISE_HI   8'h41
`define PET_ADDR_FIRST_RISE_SET  8'h42
`define PET_ADDR_FIRST_FALL_HI   8'h43
`define PET_ADDR_FIRST_FALL_SET  8'h44
`define PET_ADDR_SECOND_RISE_HI  8'h45
`define PET_ADDR_SECOND_RISE_SET 8'h46
`define PET_ADDR_SECOND_FALL_HI  8'h47
`define PET_ADDR_SECOND_FALL_SET 8'h48
`define PET_ADDR_STRIDE          8'h02

// ==========================================================
// setting register fields
`define PET_SET_LSB_HI           7
`define PET_SET_LSB_LO           4
`define PET_SET_MOD_EN_BIT       3
`define PET_SET_SIGN_BIT         2
`define PET_SET_RSVD_HI          1
`define PET_SET_RSVD_LO          0

// ==========================================================
// reset values
`define PET_TIME_HI_RST          8'h00
`define PET_SETTING_RST          8'h00
`define PET_UNMAPPED_READ        8'h00

// ==========================================================
// timing: one edge count is 5 ns, the clock is 25 ns
`define PET_STEP_PS              5000
`define PET_CLK_PS               25000
`define PET_TICKS_PER_CLK        (`PET_CLK_PS / `PET_STEP_PS)

`endif

/* verilog/pet_pkg.sv */
/*
 * types shared by the pwm edge timing block.
 * assumes: compiled before every module of the block.
 */
package pet_pkg;

   // ==========================================================
   // types
   typedef logic [11:0] pet_time_t;
   typedef logic [12:0] pet_cnt_t;
   typedef logic [7:0]  pet_byte_t;
   typedef logic [2:0]  pet_fine_t;

   typedef enum logic [1:0] {
      PET_EDGE_FIRST_RISE,
      PET_EDGE_FIRST_FALL,
      PET_EDGE_SECOND_RISE,
      PET_EDGE_SECOND_FALL
   } pet_edge_t;

   typedef enum logic [0:0] {
      PET_IDLE,
      PET_RUN
   } pet_state_t;

endpackage : pet_pkg

/* verilog/pet_edge_calc.sv */
/*
 * one edge: programmed time plus or minus the loop modulation,
 * saturated to the 12-bit range, taken at each period start.
 * assumes: load_i is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pet_edge_calc
(
   // clock and reset
   input  wire logic          mclk_i,
   input  wire logic          rst_n_i,
   // edge setting
   input  wire pet_pkg::pet_time_t base_time_i,
   input  wire logic          mod_en_i,
   input  wire logic          mod_sign_i,
   input  wire pet_pkg::pet_time_t mod_val_i,
   input  wire logic          load_i,
   // effective time
   output pet_pkg::pet_time_t eff_time_o
);
   import pet_pkg::*;

   // ==========================================================
   // next effective time
   pet_time_t eff_q;
   pet_time_t eff_d;
   pet_cnt_t  sum;

   always_comb
   begin
      eff_d = eff_q;
      sum   = {1'b0, base_time_i} + {1'b0, mod_val_i};
      if (load_i)
      begin
         if (!mod_en_i)
         begin
            eff_d = base_time_i;
         end
         else if (mod_sign_i)
         begin
            // later; clamp at the last count rather than wrap
            eff_d = sum[12] ? 12'hFFF : sum[11:0];
         end
         else if (mod_val_i > base_time_i)
         begin
            eff_d = 12'h000;
         end
         else
         begin
            eff_d = base_time_i - mod_val_i;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         eff_q <= 12'h000;
      end
      else
      begin
         eff_q <= eff_d;
      end
   end

   assign eff_time_o = eff_q;

endmodule : pet_edge_calc

`default_nettype wire

/* verilog/pet_edge_pwm.sv */
/*
 * two-output pwm edge timing: edge registers, period counter in
 * 5 ns counts, per-edge modulation and output levels with a
 * sub-clock fine delay for each transition.
 * assumes: register port, modulation value and period length
 * come from logic on mclk_i; an external delay line uses the
 * fine outputs to place each transition within the clock.
 */
// Function
// - first output rise time is timing byte high plus setting bits 7:4 low.
// - first output fall time is timing byte high plus setting bits 7:4 low.
// - second output rise time joins its timing byte and setting bits 7:4.
// - second output fall time joins its timing byte and setting bits 7:4.
// - one count of an edge time moves that edge by 5 ns.
// - setting bit 3 lets the loop modulation shift that edge.
// - setting bit 2 set pushes edge later on rising modulation, clear earlier.
// - the first output rise time high byte is its own read-write register.
`timescale 1ns/1ps
`default_nettype none
`include "pet_regs.svh"

module pet_edge_pwm
#(
   parameter int TIME_W        = 12,
   parameter int TICKS_PER_CLK = `PET_TICKS_PER_CLK
)
(
   // clock and reset
   input  wire logic               mclk_i,
   input  wire logic               rst_n_i,
   // register port
   input  wire pet_pkg::pet_byte_t reg_addr_i,
   input  wire logic               reg_wr_i,
   input  wire pet_pkg::pet_byte_t reg_wdata_i,
   output pet_pkg::pet_byte_t      reg_rdata_o,
   // loop and period control
   input  wire logic               run_i,
   input  wire pet_pkg::pet_time_t period_len_i,
   input  wire pet_pkg::pet_time_t mod_val_i,
   // outputs to the power stage
   output logic                    first_pwm_output_o,
   output pet_pkg::pet_fine_t      first_fine_o,
   output logic                    second_pwm_output_o,
   output pet_pkg::pet_fine_t      second_fine_o,
   output logic                    period_start_o
);
   import pet_pkg::*;

   // ==========================================================
   // elaboration checks
   if (TIME_W != 12)
   begin : g_bad_width
      $error("edge times are fixed at twelve bits");
   end
   if (TICKS_PER_CLK < 1 || TICKS_PER_CLK > 7)
   begin : g_bad_ticks
      $error("ticks per clock must fit the fine delay field");
   end

   localparam pet_cnt_t TICKS = 13'(TICKS_PER_CLK);

   // ==========================================================
   // register file
   pet_byte_t time_hi_q [4];
   pet_byte_t time_hi_d [4];
   pet_byte_t setting_q [4];
   pet_byte_t setting_d [4];
   pet_byte_t rdata_q;
   pet_byte_t rdata_d;
   pet_byte_t offs;

   always_comb
   begin
      offs    = reg_addr_i - `PET_ADDR_FIRST_RISE_HI;
      rdata_d = `PET_UNMAPPED_READ;
      for (int i = 0; i < 4; i++)
      begin
         time_hi_d[i] = time_hi_q[i];
         setting_d[i] = setting_q[i];
      end
      if (reg_addr_i >= `PET_ADDR_FIRST_RISE_HI &&
          reg_addr_i <= `PET_ADDR_SECOND_FALL_SET)
      begin
         if (offs[0])
         begin
            rdata_d = setting_q[offs[2:1]];
            if (reg_wr_i)
            begin
               // reserved bits kept as written, never used
               setting_d[offs[2:1]] = reg_wdata_i;
            end
         end
         else
         begin
            rdata_d = time_hi_q[offs[2:1]];
            if (reg_wr_i)
            begin
               time_hi_d[offs[2:1]] = reg_wdata_i;
            end
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < 4; i++)
         begin
            time_hi_q[i] <= `PET_TIME_HI_RST;
            setting_q[i] <= `PET_SETTING_RST;
         end
         rdata_q <= `PET_UNMAPPED_READ;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            time_hi_q[i] <= time_hi_d[i];
            setting_q[i] <= setting_d[i];
         end
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // ==========================================================
   // period counter in 5 ns counts
   pet_state_t state_q;
   pet_state_t state_d;
   pet_cnt_t   cnt_q;
   pet_cnt_t   cnt_d;
   pet_time_t  len_q;
   pet_time_t  len_d;
   logic       start_q;
   logic       start_d;
   pet_cnt_t   cnt_next;

   always_comb
   begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      len_d    = len_q;
      start_d  = 1'b0;
      cnt_next = cnt_q + TICKS;
      case (state_q)
         PET_IDLE:
         begin
            cnt_d = 13'h0000;
            if (run_i && period_len_i != 12'h000)
            begin
               state_d = PET_RUN;
               len_d   = period_len_i;
               start_d = 1'b1;
            end
         end
         PET_RUN:
         begin
            if (!run_i)
            begin
               state_d = PET_IDLE;
               cnt_d   = 13'h0000;
            end
            else if (cnt_next >= {1'b0, len_q})
            begin
               // carry the remainder so the period stays exact
               cnt_d   = cnt_next - {1'b0, len_q};
               len_d   = (period_len_i != 12'h000) ? period_len_i : len_q;
               start_d = 1'b1;
            end
            else
            begin
               cnt_d = cnt_next;
            end
         end
         default:
         begin
            state_d = PET_IDLE;
            cnt_d   = 13'h0000;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= PET_IDLE;
         cnt_q   <= 13'h0000;
         len_q   <= 12'h000;
         start_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         len_q   <= len_d;
         start_q <= start_d;
      end
   end

   assign period_start_o = start_q;

   // ==========================================================
   // per-edge effective times and hits
   pet_time_t eff   [4];
   logic      hit   [4];
   pet_fine_t fine  [4];
   logic      load;

   // new settings only take effect at a period boundary, so a
   // write never cuts a pulse short mid-period
   assign load = start_d;

   for (genvar e = 0; e < 4; e++)
   begin : g_edge
      pet_time_t base;
      pet_cnt_t  diff;

      // high byte from the timing register, low nibble from setting
      assign base = {time_hi_q[e],
                     setting_q[e][`PET_SET_LSB_HI:`PET_SET_LSB_LO]};

      pet_edge_calc u_calc (
         .mclk_i      (mclk_i),
         .rst_n_i     (rst_n_i),
         .base_time_i (base),
         .mod_en_i    (setting_q[e][`PET_SET_MOD_EN_BIT]),
         .mod_sign_i  (setting_q[e][`PET_SET_SIGN_BIT]),
         .mod_val_i   (mod_val_i),
         .load_i      (load),
         .eff_time_o  (eff[e])
      );

      // edge lands in this clock when it falls in [cnt, cnt+ticks)
      assign diff   = {1'b0, eff[e]} - cnt_q;
      assign hit[e] = (state_q == PET_RUN) && ({1'b0, eff[e]} >= cnt_q) &&
                      (diff < TICKS) && (eff[e] < len_q);
      assign fine[e] = diff[2:0];
   end

   // ==========================================================
   // output levels and fine delays
   logic      out_q [2];
   logic      out_d [2];
   pet_fine_t ofine_q [2];
   pet_fine_t ofine_d [2];

   always_comb
   begin
      for (int o = 0; o < 2; o++)
      begin
         out_d[o]   = out_q[o];
         ofine_d[o] = ofine_q[o];
         if (state_q != PET_RUN)
         begin
            out_d[o]   = 1'b0;
            ofine_d[o] = 3'h0;
         end
         else if (hit[2*o] && hit[2*o+1])
         begin
            // both edges in one clock: the later one sets the level
            if (fine[2*o] > fine[2*o+1])
            begin
               out_d[o]   = 1'b1;
               ofine_d[o] = fine[2*o];
            end
            else
            begin
               out_d[o]   = 1'b0;
               ofine_d[o] = fine[2*o+1];
            end
         end
         else if (hit[2*o])
         begin
            out_d[o]   = 1'b1;
            ofine_d[o] = fine[2*o];
         end
         else if (hit[2*o+1])
         begin
            out_d[o]   = 1'b0;
            ofine_d[o] = fine[2*o+1];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int o = 0; o < 2; o++)
         begin
            out_q[o]   <= 1'b0;
            ofine_q[o] <= 3'h0;
         end
      end
      else
      begin
         for (int o = 0; o < 2; o++)
         begin
            out_q[o]   <= out_d[o];
            ofine_q[o] <= ofine_d[o];
         end
      end
   end

   assign first_pwm_output_o  = out_q[0];
   assign first_fine_o        = ofine_q[0];
   assign second_pwm_output_o = out_q[1];
   assign second_fine_o       = ofine_q[1];

endmodule : pet_edge_pwm

`default_nettype wire

/* testbench/pet_edge_pwm_assertions.sv */
/*
 * port checker of the two-output pwm edge timing block.
 * assumes: bound to pet_edge_pwm; period length held while running.
 */
`timescale 1ns/1ps
`default_nettype none

module pet_edge_pwm_assertions
(
   // clock, reset, register port
   input wire logic               mclk_i,
   input wire logic               rst_n_i,
   input wire pet_pkg::pet_byte_t reg_addr_i,
   input wire logic               reg_wr_i,
   input wire pet_pkg::pet_byte_t reg_wdata_i,
   input wire pet_pkg::pet_byte_t reg_rdata_o,
   // period control and outputs
   input wire logic               run_i,
   input wire pet_pkg::pet_time_t period_len_i,
   input wire logic               first_pwm_output_o,
   input wire pet_pkg::pet_fine_t first_fine_o,
   input wire logic               second_pwm_output_o,
   input wire pet_pkg::pet_fine_t second_fine_o,
   input wire logic               period_start_o
);
   import pet_pkg::*;
   logic in_map;

   assign in_map = (reg_addr_i >= 8'h41) && (reg_addr_i <= 8'h48);

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // ==========================================================
   // register port
   unmapped_read_a: assert property (!in_map |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   wr_readback_a: assert property (reg_wr_i && in_map ##1 (!reg_wr_i && $stable(reg_addr_i))
      |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("write not read back");

   // ==========================================================
   // period and outputs
   // idle is entered one edge after run drops, the level follows one edge later
   idle_first_a: assert property (!run_i |-> ##2 !first_pwm_output_o)
      else $error("first output high while idle");
   idle_second_a: assert property (!run_i |-> ##2 !second_pwm_output_o)
      else $error("second output high while idle");
   period_begin_a: assert property (!run_i ##1 (run_i && period_len_i != 12'h000) |=> period_start_o)
      else $error("period did not start");
   zero_len_a: assert property (!run_i ##1 period_len_i == 12'h000 |=> !period_start_o)
      else $error("period started with zero length");
   start_pulse_a: assert property (period_start_o && period_len_i > 12'h00a |=> !period_start_o)
      else $error("period start longer than a cycle");
   fine_range_a: assert property (first_fine_o <= 3'h4 && second_fine_o <= 3'h4)
      else $error("fine delay beyond one clock");

endmodule : pet_edge_pwm_assertions

bind pet_edge_pwm pet_edge_pwm_assertions u_chk (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
   .reg_rdata_o, .run_i, .period_len_i, .first_pwm_output_o, .first_fine_o, .second_pwm_output_o,
   .second_fine_o, .period_start_o);

`default_nettype wire

/* testbench/pet_stage_model.sv */
/*
 * power stage model: times each transition from the last period
 * start in 5 ns counts, rise then fall for each output.
 * assumes: outputs settle well before the falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module pet_stage_model
(
   // gate drive inputs
   input  wire logic               mclk_i,
   input  wire logic               a_i,
   input  wire logic               b_i,
   input  wire pet_pkg::pet_fine_t a_fine_i,
   input  wire pet_pkg::pet_fine_t b_fine_i,
   input  wire logic               start_i,
   // measured edge times
   output logic [3:0][12:0]        edge_t_o
);
   import pet_pkg::*;
   int   k  = 0;
   logic pa = 1'b0;
   logic pb = 1'b0;

   // ==========================================================
   // sampled mid-cycle, clear of the launching edge
   always @(negedge mclk_i)
   begin
      // count of the hit clock, taken before a new start clears it
      if (a_i !== pa)
         edge_t_o[{1'b0, pa}] = 13'(k * 5 + a_fine_i);
      if (b_i !== pb)
         edge_t_o[{1'b1, pb}] = 13'(k * 5 + b_fine_i);
      k  = start_i ? 0 : k + 1;
      pa = a_i;
      pb = b_i;
   end

endmodule : pet_stage_model

`default_nettype wire

/* testbench/pet_edge_pwm_tb.sv */
/*
 * self-checking bench of the two-output pwm edge timing block.
 * assumes: stage model and checker compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pet_regs.svh"

module pet_edge_pwm_tb;
   import pet_pkg::*;
   logic             mclk_i       = 1'b0;
   logic             rst_n_i      = 1'b0;
   logic             reg_wr_i     = 1'b0;
   logic             run_i        = 1'b0;
   pet_byte_t        reg_addr_i   = 8'h00;
   pet_byte_t        reg_wdata_i  = 8'h00;
   pet_time_t        period_len_i = 12'h000;
   pet_time_t        mod_val_i    = 12'h000;
   pet_byte_t        reg_rdata_o;
   logic             first_pwm_output_o;
   logic             second_pwm_output_o;
   logic             period_start_o;
   pet_fine_t        first_fine_o;
   pet_fine_t        second_fine_o;
   logic [3:0][12:0] edge_t;
   logic [7:0]       lf = 8'h2d;
   pet_byte_t        rd;
   pet_byte_t        mem [10];
   pet_byte_t        set [4];
   pet_time_t        base [4];
   int               err_total  = 0;
   int               n_compared = 0;

   always #12.5 mclk_i = ~mclk_i;

   pet_edge_pwm dut (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .run_i,
      .period_len_i, .mod_val_i, .first_pwm_output_o, .first_fine_o, .second_pwm_output_o,
      .second_fine_o, .period_start_o);
   pet_stage_model u_stage (.mclk_i, .a_i(first_pwm_output_o), .b_i(second_pwm_output_o),
      .a_fine_i(first_fine_o), .b_fine_i(second_fine_o), .start_i(period_start_o), .edge_t_o(edge_t));

   // ==========================================================
   // helpers
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : lfsr

   function automatic logic [12:0] eff(input pet_time_t b, input pet_byte_t s, input pet_time_t m);
      if (!s[3])
         return {1'b0, b};
      if (s[2])
         return ({1'b0, b} + m > 4095) ? 13'h0fff : {1'b0, b} + m;
      return (m > b) ? 13'h0000 : {1'b0, b - m};
   endfunction : eff

   task automatic check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic wr(input pet_byte_t a, input pet_byte_t d);
      @(negedge mclk_i);
      reg_addr_i  = a;
      reg_wdata_i = d;
      reg_wr_i    = 1'b1;
      @(negedge mclk_i);
      reg_wr_i    = 1'b0;
   endtask : wr

   task automatic rdreg(input pet_byte_t a);
      @(negedge mclk_i);
      reg_addr_i = a;
      @(negedge mclk_i);
      rd = reg_rdata_o;
   endtask : rdreg

   task end_of_test;
      if (err_total == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // ==========================================================
   // watchdog: the run needs about 900 clocks
   initial
   begin
      #200000;
      err_total++;
      end_of_test();
   end

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (12) @(negedge mclk_i);
      rst_n_i = 1'b1;
      for (int a = 0; a < 10; a++)
      begin
         rdreg(8'(8'h40 + a));
         check("reset reg", {5'h00, rd}, 13'h0000);
         lf = lfsr(lf);
         mem[a] = (a == 0 || a == 9) ? 8'h00 : lf;
         wr(8'(8'h40 + a), lf);
      end
      for (int a = 0; a < 10; a++)
      begin
         rdreg(8'(8'h40 + a));
         check("reg read", {5'h00, rd}, {5'h00, mem[a]});
      end
      // no modulation, then later by 60, then earlier by 150 to hit the clamp;
      // the last run starts with its length already set
      for (int r = 0; r < 3; r++)
      begin
         run_i        = 1'b0;
         period_len_i = (r == 2) ? 12'h190 : 12'h000;
         mod_val_i    = (r == 2) ? 12'h096 : 12'h03c;
         for (int e = 0; e < 4; e++)
         begin
            lf      = lfsr(lf);
            base[e] = 12'((e % 2 ? 200 : 10) + lf % 120);
            set[e]  = {base[e][3:0], r != 0, r == 1, 2'b00};
            wr(8'(`PET_ADDR_FIRST_RISE_HI + 2 * e), base[e][11:4]);
            wr(8'(`PET_ADDR_FIRST_RISE_SET + 2 * e), set[e]);
         end
         check("idle outputs", {11'h000, first_pwm_output_o, second_pwm_output_o}, 13'h0000);
         run_i = 1'b1;
         repeat (4) @(negedge mclk_i);
         period_len_i = 12'h190;
         repeat (250) @(negedge mclk_i);
         for (int e = 0; e < 4; e++)
            check("edge time", edge_t[e], eff(base[e], set[e], mod_val_i));
      end
      end_of_test();
   end

endmodule : pet_edge_pwm_tb

`default_nettype wire
